// file: rtl/alt_low_threshold_regs.sv
/*
 Low alarm limit registers and command read-back behind a serial host port.
 Frame: chip select low, 16 command bits sampled on SCLK rising edges,
 {addr[6:0], wr, data[7:0]} MSB first; reply shifted out on falling edges.
 Assumes SCLK, CS and SDI synchronous to clk_sys, each SCLK level lasting
 at least two clk_sys cycles.
*/
// Overview of operation
// - Per channel read/write upper limit byte
// - Lower register bits 7-2 hold limit low bits
// - Lower register bits 1-0 read as zero
// - Channel zero upper byte at 18h
// - Channel zero lower register at 19h
// - Read-only command read-back register at 3Fh
// - Read-back returns upper byte of the previous complete 16-bit command
// - Reply starts at 16th falling edge, MSB first
// - Content in first eight bits, then zeros
`timescale 1ns/10ps
`include "alt_cfg.svh"

module alt_low_threshold_regs import alt_pkg::*; #(
	parameter int NUM_CH = `ALT_NUM_CH
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input alt_pins_t pins,
	output logic sdo,
	output logic [15:0] lastCmd
);
	localparam int MW = $clog2(2 * NUM_CH);

	alt_frame_t frame_ff;
	logic sclkPrev_ff;
	logic [3:0] riseCnt_ff;
	logic [4:0] fallCnt_ff;
	logic [14:0] shiftIn_ff;
	logic [15:0] prevCmd_ff;
	logic [7:0] rbByte_ff;
	alt_src_t src_ff;
	logic [15:0] outSr_ff;
	logic sclkRise;
	logic sclkFall;
	logic cmdDone;
	alt_cmd_t cmdWord;
	logic [MW:0] slot;
	logic [MW-1:0] memAddr;
	logic [MW-1:0] rdSlot_ff;
	logic [7:0] memRd;
	logic memWrEn;
	logic [7:0] memWrData;
	logic [7:0] replyByte;

	// Maps an address to {hit, byte slot}; slot LSB set for the lower register
	function automatic logic [MW:0] limitSlot(input logic [`ALT_ADDR_W-1:0] addr);
		logic [`ALT_ADDR_W-1:0] off;
		logic [`ALT_ADDR_W-1:0] ch;
		logic [`ALT_ADDR_W-1:0] sub;
		logic hit;
		off = addr - `ALT_ADDR_CH0_UPPER;
		ch = off / `ALT_CH_STRIDE;
		sub = off % `ALT_CH_STRIDE;
		hit = (addr >= `ALT_ADDR_CH0_UPPER) && (32'(ch) < NUM_CH)
			&& (sub <= (`ALT_ADDR_CH0_LOWER - `ALT_ADDR_CH0_UPPER));
		limitSlot = {hit, MW'({ch, sub[0]})};
	endfunction

	assign sclkRise = pins.sclk && !sclkPrev_ff;
	assign sclkFall = !pins.sclk && sclkPrev_ff;
	assign cmdDone = (frame_ff == FR_CMD) && sclkRise && (riseCnt_ff == `ALT_CMD_LAST_BIT);
	assign cmdWord = {shiftIn_ff, pins.sdi};
	assign slot = limitSlot(cmdWord.addr);
	assign memAddr = slot[MW-1:0];

	// Upper bytes take all bits, lower registers keep bits 1-0 at zero
	assign memWrEn = cmdDone && cmdWord.wr && slot[MW];
	assign memWrData = slot[0] ? (cmdWord.data & `ALT_LOWER_WR_MASK)
		: cmdWord.data;

	alt_reg_mem #(
		.DEPTH(2 * NUM_CH),
		.AW(MW),
		.DW(8)
	) u_mem (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.wrEn(memWrEn),
		.wrAddr(memAddr),
		.wrData(memWrData),
		.rdAddr(rdSlot_ff),
		.rdData(memRd)
	);

	// Hold the read slot: the command shifter moves on after the 16th rise
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rdSlot_ff <= '0;
		end else if (cmdDone) begin
			rdSlot_ff <= memAddr;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sclkPrev_ff <= 1'b0;
		end else begin
			sclkPrev_ff <= pins.sclk;
		end
	end

	// Frame sequencing; chip select high aborts any frame
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			frame_ff <= FR_IDLE;
			riseCnt_ff <= 4'h0;
			shiftIn_ff <= '0;
		end else if (pins.csN) begin
			frame_ff <= FR_IDLE;
			riseCnt_ff <= 4'h0;
		end else begin
			unique case (frame_ff)
				FR_IDLE: begin
					frame_ff <= FR_CMD;
				end
				FR_CMD: begin
					if (sclkRise) begin
						shiftIn_ff <= cmdWord[14:0];
						riseCnt_ff <= riseCnt_ff + 4'h1;
					end
					if (cmdDone) begin
						frame_ff <= FR_REPLY;
					end
				end
				FR_REPLY: begin
					frame_ff <= FR_REPLY;
				end
			endcase
		end
	end

	// Command history; read-back captures the upper byte of the word before this one
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			prevCmd_ff <= `ALT_READBACK_RESET;
			rbByte_ff <= 8'h00;
			src_ff <= SRC_NONE;
		end else if (cmdDone) begin
			prevCmd_ff <= cmdWord;
			rbByte_ff <= prevCmd_ff[15:8];
			if (cmdWord.wr) begin
				src_ff <= SRC_NONE;
			end else if (cmdWord.addr == `ALT_ADDR_READBACK) begin
				src_ff <= SRC_READBACK;
			end else if (slot[MW]) begin
				src_ff <= SRC_LIMIT;
			end else begin
				src_ff <= SRC_NONE;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			lastCmd <= `ALT_READBACK_RESET;
		end else begin
			lastCmd <= prevCmd_ff;
		end
	end

	always_comb begin
		unique case (src_ff)
			SRC_LIMIT: replyByte = memRd;
			SRC_READBACK: replyByte = rbByte_ff;
			default: replyByte = 8'h00;
		endcase
	end

	// Reply shifter: loads at the 16th falling edge, zeros after eight bits
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			fallCnt_ff <= 5'h00;
			outSr_ff <= 16'h0000;
			sdo <= 1'b0;
		end else if (pins.csN) begin
			fallCnt_ff <= 5'h00;
			outSr_ff <= 16'h0000;
			sdo <= 1'b0;
		end else if (sclkFall && frame_ff != FR_IDLE) begin
			if (fallCnt_ff != `ALT_FALL_MAX) begin
				fallCnt_ff <= fallCnt_ff + 5'h01;
			end
			if (frame_ff == FR_REPLY && fallCnt_ff == `ALT_REPLY_FALL) begin
				sdo <= replyByte[7];
				outSr_ff <= {replyByte[6:0], 9'h000};
			end else begin
				sdo <= outSr_ff[15];
				outSr_ff <= {outSr_ff[14:0], 1'b0};
			end
		end
	end
endmodule

// file: rtl/alt_cfg.svh
/*
 Constants of the low alarm limit bank: register addresses, field masks,
 reset values and serial frame counts.
 Assumes inclusion by the package and the design modules only.
*/
`ifndef ALT_CFG_SVH
`define ALT_CFG_SVH

`define ALT_ADDR_W 7
`define ALT_ADDR_CH0_UPPER 7'h18
`define ALT_ADDR_CH0_LOWER 7'h19
`define ALT_ADDR_READBACK 7'h3F
`define ALT_CH_STRIDE 7'h05
`define ALT_NUM_CH 8
`define ALT_LIMIT_RESET 8'h00
`define ALT_READBACK_RESET 16'h0000
`define ALT_LOWER_WR_MASK 8'hFC
`define ALT_CMD_BITS 16
`define ALT_CMD_LAST_BIT 4'hF
`define ALT_REPLY_FALL 5'h0F
`define ALT_FALL_MAX 5'h1F

`endif

// file: rtl/alt_pkg.sv
/*
 Types of the low alarm limit bank: serial pin group, command word
 layout and serial frame states.
 Assumes the constants header is on the include path.
*/
`include "alt_cfg.svh"

package alt_pkg;
	typedef struct packed {
		logic sclk;
		logic csN;
		logic sdi;
	} alt_pins_t;

	typedef struct packed {
		logic [`ALT_ADDR_W-1:0] addr;
		logic wr;
		logic [7:0] data;
	} alt_cmd_t;

	typedef enum logic [1:0] {
		FR_IDLE = 2'b00,
		FR_CMD = 2'b01,
		FR_REPLY = 2'b11
	} alt_frame_t;

	typedef enum logic [1:0] {
		SRC_NONE = 2'b00,
		SRC_LIMIT = 2'b01,
		SRC_READBACK = 2'b10
	} alt_src_t;
endpackage

// file: rtl/alt_reg_mem.sv
/*
 Small byte memory holding the low alarm limit bytes, two per channel.
 Read data come out of a register one cycle after the address.
 Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`include "alt_cfg.svh"

module alt_reg_mem #(
	parameter int DEPTH = 16,
	parameter int AW = 4,
	parameter int DW = 8
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [DW-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [DW-1:0] rdData
);
	logic [DW-1:0] mem_ff [DEPTH];

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= DW'(`ALT_LIMIT_RESET);
			end
		end else if (wrEn) begin
			mem_ff[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rdData <= '0;
		end else begin
			rdData <= mem_ff[rdAddr];
		end
	end
endmodule

// file: dv/alt_checker.sv
/* Assertions on the limit bank serial port. Bound to the top module. */
`timescale 1ns/10ps
module alt_checker import alt_pkg::*; (
	input wire logic clk_sys,
	input wire logic rstn,
	input alt_pins_t pins,
	input wire logic sdo,
	input wire logic [15:0] lastCmd
);
	logic sclk_ff;
	logic [5:0] rise_ff;
	logic [5:0] fall_ff;
	logic [15:0] sh_ff;
	wire rise = pins.sclk && !sclk_ff && !pins.csN;
	wire fall = !pins.sclk && sclk_ff && !pins.csN;
	always_ff @(posedge clk_sys) begin
		sclk_ff <= pins.sclk;
	end
	// Edge counts within the frame
	always_ff @(posedge clk_sys) begin
		if (!rstn || pins.csN) begin
			rise_ff <= 6'h00;
			fall_ff <= 6'h00;
		end else begin
			rise_ff <= rise_ff + {5'h00, rise};
			fall_ff <= fall_ff + {5'h00, fall};
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rise && rise_ff < 6'h10) begin
			sh_ff <= {sh_ff[14:0], pins.sdi};
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_idle_zero: assert property (pins.csN && $past(pins.csN) |-> !sdo)
		else $error("sdo high outside frame");
	a_no_early: assert property ((!pins.csN && fall_ff < 6'h10) [*2] |-> !sdo)
		else $error("reply before 16th fall");
	a_tail_zero: assert property ((!pins.csN && fall_ff > 6'h17) [*3] |-> !sdo)
		else $error("reply tail not zero");
	a_hist_capture: assert property ($changed(lastCmd) |-> rise_ff == 6'h10 && lastCmd == sh_ff)
		else $error("history differs from command");
	a_hist_inframe: assert property ($changed(lastCmd) |-> !pins.csN)
		else $error("history changed outside frame");
	a_late_ignored: assert property (rise_ff > 6'h10 |-> $stable(lastCmd))
		else $error("rise after 16th changed history");
	a_sdo_at_fall: assert property ($changed(sdo) |-> !$past(pins.sclk) || $past(pins.csN))
		else $error("sdo moved while sclk high");
	a_write_quiet: assert property (!pins.csN && rise_ff > 6'h0F && sh_ff[8] |-> !sdo)
		else $error("write frame replied");
endmodule
bind alt_low_threshold_regs alt_checker u_chk (.clk_sys(clk_sys), .rstn(rstn), .pins(pins),
	.sdo(sdo), .lastCmd(lastCmd));

// file: dv/alt_host_model.sv
/* Serial host model. Assumes clk_sys; sclk idles low, each level 4 clocks. */
`timescale 1ns/10ps
module alt_host_model import alt_pkg::*; (
	input wire logic clk_sys,
	input wire logic sdo,
	output alt_pins_t pins
);
	initial begin
		pins = 3'b010;
	end
	// Frame length n is the caller's; a read-back may stop at 24
	task automatic xfer(input logic [15:0] cmd, input int n, output logic [15:0] rep);
		rep = 16'h0000;
		@(posedge clk_sys);
		#1 pins.csN = 1'b0;
		for (int i = 0; i < n; i++) begin
			pins.sdi = (i < 16) ? cmd[15 - i] : ~pins.sdi;
			repeat (4) @(posedge clk_sys);
			#1;
			if (i > 15) rep[31 - i] = sdo;
			pins.sclk = 1'b1;
			repeat (4) @(posedge clk_sys);
			#1 pins.sclk = 1'b0;
		end
		repeat (4) @(posedge clk_sys);
		#1;
		if (n > 15 && n < 32) rep[31 - n] = sdo;
		pins.csN = 1'b1;
		pins.sdi = ~pins.sdi;
		repeat (4) @(posedge clk_sys);
	endtask
endmodule

// file: dv/alt_low_threshold_regs_tb.sv
/* Bench of the limit bank. Frames go through the host model. */
`timescale 1ns/10ps
module alt_low_threshold_regs_tb import alt_pkg::*;;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	alt_pins_t pins;
	logic sdo;
	logic [15:0] lastCmd;
	logic [15:0] rep;
	int fail_count = 0;
	int checks_done = 0;
	always #50 clk_sys = ~clk_sys;
	alt_low_threshold_regs u_dut (.clk_sys(clk_sys), .rstn(rstn), .pins(pins), .sdo(sdo),
		.lastCmd(lastCmd));
	alt_host_model u_host (.clk_sys(clk_sys), .sdo(sdo), .pins(pins));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Frame word is {addr, wr, data}
	task automatic fr(input logic [15:0] cmd, input int n, input logic [7:0] exp);
		u_host.xfer(cmd, n, rep);
		check(rep, {exp, 8'h00});
		if (n > 15) check(lastCmd, cmd);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		#1 rstn = 1'b1;
		fr(16'h3000, 32, 8'h00);
		fr(16'h3200, 32, 8'h00);
		fr(16'h7600, 32, 8'h00);
		fr(16'h7E00, 32, 8'h76);
		fr(16'h31AA, 32, 8'h00);
		fr(16'h33FF, 32, 8'h00);
		fr(16'h775A, 24, 8'h00);
		fr(16'h7F00, 32, 8'h00);
		fr(16'hFD33, 32, 8'h00);
		fr(16'h3000, 32, 8'hAA);
		fr(16'h3200, 32, 8'hFC);
		fr(16'h7600, 32, 8'h5A);
		repeat (4) @(posedge clk_sys);
		#1 rstn = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1 rstn = 1'b1;
		fr(16'h7E00, 32, 8'h00);
		fr(16'h3000, 32, 8'h00);
		fr(16'hFC00, 32, 8'h00);
		fr(16'h3200, 10, 8'h00);
		fr(16'h7E00, 24, 8'hFC);
		fr(16'h7E00, 32, 8'h7E);
		conclude();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		conclude();
	end
endmodule
